// ### core/meter_converter_ctrl.sv
/*
  APB register block for the meter converter filter chain: run and
  clear control, busy bits, sticky flags with enables, results, peak
  holds and the reference/clock-input control register.
  Assumes filter stages deliver one-cycle done pulses with results,
  that stage busy levels and data inputs are synchronous to pclk,
  and that the APB master keeps the two-phase setup/access order.
  The slave answers with no wait states and never flags an error;
  unmapped offsets read zero and ignore writes.
*/
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module meter_converter_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Filter chain status in
  // Stage busy levels: sqrt, averaging, highpass, lowpass, comb
  input wire logic [4:0] stage_busy,
  // Stage done pulses, bit 0 comb .. bit 3 averaging, bit 4 sqrt
  input wire logic [4:0] stage_done,
  input wire logic continuity_change,
  // Result and peak sample data in
  input wire logic [15:0] comb_data,
  input wire logic [15:0] lowpass_data,
  input wire logic [15:0] highpass_data,
  input wire logic [31:0] ac_data,
  input wire logic dc_peak_valid,
  input wire logic [15:0] dc_peak_sample,
  input wire logic ac_peak_valid,
  input wire logic [31:0] ac_peak_sample,
  // Controls out to the chain and the analog section
  output logic conversion_run,
  output logic filter_clear,
  output logic analog_clock_gate,
  output logic reference_enable,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Both clear sequencers share one two-state encoding
  typedef enum {CLR_IDLE, CLR_BUSY} clr_state_t;
  clr_state_t peak_st_r; // Peak clear sequencer
  clr_state_t filt_st_r; // Filter clear sequencer
  // Down counters, wide enough for the four microsecond peak clear
  logic [9:0] peak_cnt_r; // Peak clear cycles left
  logic [9:0] filt_cnt_r; // Filter clear cycles left
  // Software-written control state
  logic run_r; // Conversion run bit
  logic [10:0] ie_r; // Enables
  logic [10:0] if_r; // Sticky flags
  logic [15:0] conf_r; // Filter select and peak enable
  logic [15:0] mode_r; // Mode and range
  logic [15:0] refctl_r; // Reference and clock-input control
  // Result and peak hold words as software sees them
  logic [15:0] comb_r, lphp_r, dcmax_r, dcmin_r;
  logic [31:0] ac_r, acmax_r, acmin_r;
  // Bus side helpers
  logic [31:0] prdata_r; // Read word, captured in the setup phase
  logic irq_r; // Registered interrupt request
  logic [15:0] rd_val; // Read mux output
  logic wr_en; // Write in its access phase
  logic [10:0] ev_set; // Flag causes this cycle
  logic [10:0] flag_clr; // Write-one-to-clear mask

  // Writes take effect in the access phase; with no wait states the
  // access phase is always the single cycle after setup
  assign wr_en = psel & penable & pwrite;
  // Only a write to the flag word clears flags
  assign flag_clr = (wr_en && paddr == meter_converter_pkg::OFS_IF) ?
                    pwdata[10:0] : 11'h000;

  // ----------------------------------------------------------------
  // Event collection
  // ----------------------------------------------------------------
  // Done flags at 0..3, sqrt done at 8; overwrite when done still set
  // One slice per filter stage: completion and overwrite causes
  for (genvar g = 0; g < 4; g++) begin : g_stage
    // Done pulse raises the completion flag
    assign ev_set[g] = stage_done[g];
    // Overwrite reads the flag before this cycle's set, so the
    // first result after a clear never counts as an overwrite
    assign ev_set[meter_converter_pkg::OVR_LSB + g] =
      stage_done[g] & if_r[g];
  end
  // Square root stage and continuity sit above the four stages
  assign ev_set[meter_converter_pkg::SQRT_DONE] = stage_done[4];
  assign ev_set[meter_converter_pkg::SQRT_OVR] =
    stage_done[4] & if_r[meter_converter_pkg::SQRT_DONE];
  assign ev_set[meter_converter_pkg::CONT_FLAG] = continuity_change;

  // Flags: set wins over a clear in the same cycle, so an event
  // landing on a clearing write is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      if_r <= 11'h000;
    end else begin
      if_r <= (if_r & ~flag_clr) | ev_set;
    end
  end

  // Interrupt request from enabled flags
  // Registered, so it follows a flag or enable change by a cycle
  // Enables gate the request only; flags still set while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(if_r & ie_r);
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Software control words; the clear strobes live in the sequencers
  // Writing the init word also rewrites the run bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      ie_r <= 11'h000;
      conf_r <= meter_converter_pkg::ZERO16;
      mode_r <= meter_converter_pkg::ZERO16;
    end else if (wr_en) begin
      case (paddr)
        meter_converter_pkg::OFS_INIT: begin
          run_r <= pwdata[meter_converter_pkg::BIT_RUN];
        end
        meter_converter_pkg::OFS_IE: begin
          ie_r <= pwdata[10:0];
        end
        meter_converter_pkg::OFS_CONF: begin
          conf_r <= pwdata[15:0];
        end
        meter_converter_pkg::OFS_MODE: begin
          mode_r <= pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Reference control: direct writes or reload on a mode write
  // Non-off modes switch the clock gate and reference on
  // A later direct write can still override the loaded value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refctl_r <= meter_converter_pkg::REFCTL_RST;
    end else if (wr_en && paddr == meter_converter_pkg::OFS_MODE) begin
      if (pwdata[3:0] == meter_converter_pkg::MODE_OFF) begin
        refctl_r <= meter_converter_pkg::REFCTL_OFF;
      end else begin
        refctl_r <= meter_converter_pkg::REFCTL_RUN;
      end
    end else if (wr_en && paddr == meter_converter_pkg::OFS_REFCTL) begin
      refctl_r <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Clear sequencers
  // ----------------------------------------------------------------
  // Peak clear lasts a fixed count inside the four microsecond limit
  // A second strobe while busy is ignored; the count is not restarted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_st_r <= CLR_IDLE;
      peak_cnt_r <= '0;
    end else begin
      case (peak_st_r)
        CLR_IDLE: begin
          if (wr_en && paddr == meter_converter_pkg::OFS_INIT &&
              pwdata[meter_converter_pkg::BIT_PEAK_CLR]) begin
            peak_st_r <= CLR_BUSY;
            peak_cnt_r <= 10'(meter_converter_pkg::PEAK_CLR_CYC);
          end
        end
        CLR_BUSY: begin
          // Count reaches zero: release the strobe
          if (peak_cnt_r == '0) begin
            peak_st_r <= CLR_IDLE;
          end else begin
            peak_cnt_r <= peak_cnt_r - 10'h001;
          end
        end
        default: begin
          peak_st_r <= CLR_IDLE;
        end
      endcase
    end
  end

  // Filter clear holds the chain in reset for a short count
  // Its state also drives the filter_clear output to the chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_st_r <= CLR_IDLE;
      filt_cnt_r <= '0;
    end else begin
      case (filt_st_r)
        CLR_IDLE: begin
          if (wr_en && paddr == meter_converter_pkg::OFS_INIT &&
              pwdata[meter_converter_pkg::BIT_FILT_CLR]) begin
            filt_st_r <= CLR_BUSY;
            filt_cnt_r <= 10'(meter_converter_pkg::FILT_CLR_CYC);
          end
        end
        CLR_BUSY: begin
          // Count reaches zero: release the strobe
          if (filt_cnt_r == '0) begin
            filt_st_r <= CLR_IDLE;
          end else begin
            filt_cnt_r <= filt_cnt_r - 10'h001;
          end
        end
        default: begin
          filt_st_r <= CLR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  // Filter clear empties results; new data is dropped while clearing
  // The unselected filter's result never reaches the shared word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comb_r <= meter_converter_pkg::ZERO16;
      lphp_r <= meter_converter_pkg::ZERO16;
      ac_r <= '0;
    end else if (filt_st_r == CLR_BUSY) begin
      comb_r <= meter_converter_pkg::ZERO16;
      lphp_r <= meter_converter_pkg::ZERO16;
      ac_r <= '0;
    end else begin
      // Comb result follows every comb completion
      if (stage_done[0]) begin
        comb_r <= comb_data;
      end
      if (conf_r[meter_converter_pkg::BIT_FSEL] && stage_done[1]) begin
        lphp_r <= lowpass_data;
      end else if (!conf_r[meter_converter_pkg::BIT_FSEL] &&
                   stage_done[2]) begin
        lphp_r <= highpass_data;
      end
      // AC word from averaging or square root, whichever completes
      if (stage_done[3] || stage_done[4]) begin
        ac_r <= ac_data;
      end
    end
  end

  // Peak holds: cleared by the strobe, updated only when enabled
  // Disabling peak hold keeps the held values; only the strobe clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcmax_r <= meter_converter_pkg::DCMAX_INIT;
      dcmin_r <= meter_converter_pkg::DCMIN_INIT;
      acmax_r <= '0;
      acmin_r <= '0;
    end else if (peak_st_r == CLR_BUSY) begin
      dcmax_r <= meter_converter_pkg::DCMAX_INIT;
      dcmin_r <= meter_converter_pkg::DCMIN_INIT;
      acmax_r <= '0;
      acmin_r <= '0;
    end else if (conf_r[meter_converter_pkg::BIT_PEAK_ON]) begin
      // Signed compares for the DC extremes
      if (dc_peak_valid &&
          $signed(dc_peak_sample) > $signed(dcmax_r)) begin
        dcmax_r <= dc_peak_sample;
      end
      if (dc_peak_valid &&
          $signed(dc_peak_sample) < $signed(dcmin_r)) begin
        dcmin_r <= dc_peak_sample;
      end
      // AC minimum of zero means empty, so first sample loads it
      if (ac_peak_valid && ac_peak_sample > acmax_r) begin
        acmax_r <= ac_peak_sample;
      end
      if (ac_peak_valid &&
          (acmin_r == '0 || ac_peak_sample < acmin_r)) begin
        acmin_r <= ac_peak_sample;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Address decode of the read word; unmapped offsets read zero
  // Busy bits come straight from the stage levels, unregistered
  always_comb begin
    rd_val = meter_converter_pkg::ZERO16;
    case (paddr)
      // Strobes read 1 while their sequencer is busy
      meter_converter_pkg::OFS_INIT: begin
        rd_val[meter_converter_pkg::BIT_PEAK_CLR] =
          (peak_st_r == CLR_BUSY);
        rd_val[meter_converter_pkg::BIT_FILT_CLR] =
          (filt_st_r == CLR_BUSY);
        rd_val[meter_converter_pkg::BIT_RUN] = run_r;
      end
      // Upper enable bits read zero
      meter_converter_pkg::OFS_IE: rd_val = {5'h00, ie_r};
      // Busy levels sit above the eleven flags
      meter_converter_pkg::OFS_IF: rd_val = {stage_busy, if_r};
      // Results and peak holds, low word at the lower offset
      meter_converter_pkg::OFS_COMB: rd_val = comb_r;
      meter_converter_pkg::OFS_LPHP: rd_val = lphp_r;
      meter_converter_pkg::OFS_AC_LO: rd_val = ac_r[15:0];
      meter_converter_pkg::OFS_AC_HI: rd_val = ac_r[31:16];
      meter_converter_pkg::OFS_DCMAX: rd_val = dcmax_r;
      meter_converter_pkg::OFS_DCMIN: rd_val = dcmin_r;
      meter_converter_pkg::OFS_ACMAX_LO: rd_val = acmax_r[15:0];
      meter_converter_pkg::OFS_ACMAX_HI: rd_val = acmax_r[31:16];
      meter_converter_pkg::OFS_ACMIN_LO: rd_val = acmin_r[15:0];
      meter_converter_pkg::OFS_ACMIN_HI: rd_val = acmin_r[31:16];
      meter_converter_pkg::OFS_REFCTL: rd_val = refctl_r;
      meter_converter_pkg::OFS_CONF: rd_val = conf_r;
      meter_converter_pkg::OFS_MODE: rd_val = mode_r;
      default: rd_val = meter_converter_pkg::ZERO16;
    endcase
  end

  // Read data registered from the setup phase
  // Captured at the setup edge so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= {16'h0000, rd_val};
    end
  end

  // Outputs from flops; pready registered from the setup phase, pslverr a constant flop output
  // Control outputs lag their register bits by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      conversion_run <= 1'b0;
      filter_clear <= 1'b0;
      analog_clock_gate <= 1'b0;
      reference_enable <= 1'b0;
    end else begin
      // Zero-wait answer: ready in every access phase
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      // Chain and analog controls
      conversion_run <= run_r;
      filter_clear <= (filt_st_r == CLR_BUSY);
      analog_clock_gate <=
        refctl_r[meter_converter_pkg::BIT_CLK_GATE];
      reference_enable <=
        refctl_r[meter_converter_pkg::BIT_REF_EN];
    end
  end

  assign prdata = prdata_r;
  assign irq = irq_r;

endmodule

// ### core/meter_converter_pkg.sv
/*
  Constants for the meter converter filter control block: register
  offsets, bit positions, reset values and clearing times.
  Assumes a 32-bit APB bus with one register per aligned word.
*/
package meter_converter_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INIT = 8'h00;
  localparam logic [7:0] OFS_IE = 8'h04;
  localparam logic [7:0] OFS_IF = 8'h08;
  localparam logic [7:0] OFS_COMB = 8'h0c;
  localparam logic [7:0] OFS_LPHP = 8'h10;
  localparam logic [7:0] OFS_AC_LO = 8'h14;
  localparam logic [7:0] OFS_AC_HI = 8'h18;
  localparam logic [7:0] OFS_DCMAX = 8'h1c;
  localparam logic [7:0] OFS_DCMIN = 8'h20;
  localparam logic [7:0] OFS_ACMAX_LO = 8'h24;
  localparam logic [7:0] OFS_ACMAX_HI = 8'h28;
  localparam logic [7:0] OFS_ACMIN_LO = 8'h2c;
  localparam logic [7:0] OFS_ACMIN_HI = 8'h30;
  localparam logic [7:0] OFS_REFCTL = 8'h34;
  localparam logic [7:0] OFS_CONF = 8'h38;
  localparam logic [7:0] OFS_MODE = 8'h3c;

  // ----------------------------------------------------------------
  // Bit positions
  // ----------------------------------------------------------------
  localparam int BIT_PEAK_CLR = 9;
  localparam int BIT_FILT_CLR = 8;
  localparam int BIT_RUN = 1;
  localparam int BIT_CLK_GATE = 8;
  localparam int BIT_REF_EN = 0;
  localparam int BIT_FSEL = 6;
  localparam int BIT_PEAK_ON = 5;
  localparam int NUM_FLAGS = 11;
  localparam int NUM_STAGES = 5;
  localparam int BUSY_LSB = 11;
  localparam int OVR_LSB = 4;
  localparam int SQRT_DONE = 8;
  localparam int SQRT_OVR = 9;
  localparam int CONT_FLAG = 10;

  // ----------------------------------------------------------------
  // Reset, reference load and mode values
  // ----------------------------------------------------------------
  localparam logic [15:0] DCMAX_INIT = 16'h8000;
  localparam logic [15:0] DCMIN_INIT = 16'h7fff;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] REFCTL_RST = 16'h00c4;
  localparam logic [15:0] REFCTL_RUN = 16'h01c5;
  localparam logic [15:0] REFCTL_OFF = 16'h00c4;
  localparam logic [3:0] MODE_OFF = 4'h9;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int PEAK_CLR_NS = 4000;
  localparam int FILT_CLR_CYC = 16;
  localparam int PEAK_CLR_CYC = (PEAK_CLR_NS * CLK_MHZ) / 1000 - 1;
  localparam int CNT_W = 10;

endpackage

// ### testbench/meter_converter_ctrl_tb.sv
/*
  Self-checking bench for the meter converter control block.
  Assumes package, block and checker are compiled before it.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected %s exp %h got %h", n, e, g); end end
module meter_converter_ctrl_tb;
  // ----------
  // Signals
  // ----------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic conversion_run, filter_clear, analog_clock_gate, reference_enable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, ac_data, ac_peak_sample;
  logic [4:0] stage_busy, stage_done;
  logic continuity_change, dc_peak_valid, ac_peak_valid;
  logic [15:0] comb_data, lowpass_data, highpass_data, dc_peak_sample;
  logic [1:0] ro; // Clock gate and reference enable together
  int err_total = 0;
  int n_compared = 0;
  int t0, cyc = 0; // Cycle count for the clear time
  // Reset value of each word from offset 0 to offset 0x34
  logic [15:0] rv [14] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h8000, 16'h7fff, 16'h0, 16'h0, 16'h0, 16'h0, 16'h00c4};
  assign ro = {analog_clock_gate, reference_enable};
  meter_converter_ctrl meter_converter_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stage_busy(stage_busy),
    .stage_done(stage_done), .continuity_change(continuity_change),
    .comb_data(comb_data), .lowpass_data(lowpass_data),
    .highpass_data(highpass_data), .ac_data(ac_data),
    .dc_peak_valid(dc_peak_valid), .dc_peak_sample(dc_peak_sample),
    .ac_peak_valid(ac_peak_valid), .ac_peak_sample(ac_peak_sample),
    .conversion_run(conversion_run), .filter_clear(filter_clear),
    .analog_clock_gate(analog_clock_gate),
    .reference_enable(reference_enable), .irq(irq)
  );
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  // ----------
  // Tasks
  // ----------
  task automatic close_out();
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; read data lands in rd at the ready edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // A slave that never answers ends the run
    if (i == 16) begin
      `CHK("pready", 1'b1, 1'b0)
      close_out();
    end
  endtask
  task automatic rchk(input string s, input logic [7:0] a,
                      input logic [15:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(s, {16'h0, e}, rd)
    `CHK("slverr", 1'b0, pslverr)
  endtask
  // Poll a clear strobe until it drops; bounded
  task automatic wait_low(input int b);
    int n;
    for (n = 0; n < 400; n++) begin
      xfer(1'b0, 8'h00, 32'h0);
      if (rd[b] === 1'b0) break;
    end
    if (n == 400) begin
      `CHK("strobe", 1'b0, rd[b])
      close_out();
    end
  endtask
  // Event pulses for one cycle
  task automatic pulse(input logic [4:0] d, input logic c,
                       input logic [1:0] p);
    @(posedge pclk);
    stage_done <= d;
    continuity_change <= c;
    {ac_peak_valid, dc_peak_valid} <= p;
    @(posedge pclk);
    stage_done <= 5'h0;
    continuity_change <= 1'b0;
    {ac_peak_valid, dc_peak_valid} <= 2'b0;
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    {psel, penable, pwrite, stage_busy, stage_done} = '0;
    {continuity_change, dc_peak_valid, ac_peak_valid} = '0;
    {paddr, pwdata, comb_data, lowpass_data, highpass_data} = '0;
    {dc_peak_sample, ac_data, ac_peak_sample} = '0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an ignored unmapped write
    for (int k = 0; k < 14; k++)
      rchk("reset", 8'(k * 4), rv[k]);
    xfer(1'b1, 8'h40, 32'hffff);
    rchk("unmapped", 8'h40, 16'h0);
    xfer(1'b1, 8'h04, '1);
    rchk("enable", 8'h04, 16'h07ff);
    xfer(1'b1, 8'h00, 32'h2);
    rchk("run", 8'h00, 16'h0002);
    `CHK("run out", 1'b1, conversion_run)
    // Busy bits follow the stage levels
    stage_busy <= 5'b10101;
    rchk("busy", 8'h08, 16'ha800);
    stage_busy <= 5'b01010;
    rchk("busy", 8'h08, 16'h5000);
    stage_busy <= 5'b0;
    xfer(1'b1, 8'h04, 32'h0);
    comb_data <= 16'h8123;
    highpass_data <= 16'h4567;
    lowpass_data <= 16'h1234;
    ac_data <= 32'hdead_beef;
    pulse(5'h1f, 1'b1, 2'b0);
    rchk("flags", 8'h08, 16'h050f);
    rchk("comb", 8'h0c, 16'h8123);
    rchk("hp", 8'h10, 16'h4567);
    rchk("ac lo", 8'h14, 16'hbeef);
    rchk("ac hi", 8'h18, 16'hdead);
    `CHK("irq", 1'b0, irq)
    // Second result while done flags stand
    pulse(5'h1f, 1'b1, 2'b0);
    rchk("flags", 8'h08, 16'h07ff);
    xfer(1'b1, 8'h08, 32'h0);
    rchk("flags", 8'h08, 16'h07ff);
    xfer(1'b1, 8'h04, 32'h400);
    rchk("flags", 8'h08, 16'h07ff);
    `CHK("irq", 1'b1, irq)
    xfer(1'b1, 8'h08, 32'h400);
    rchk("flags", 8'h08, 16'h03ff);
    `CHK("irq", 1'b0, irq)
    xfer(1'b1, 8'h38, 32'h40);
    pulse(5'h06, 1'b0, 2'b0);
    rchk("lp", 8'h10, 16'h1234);
    xfer(1'b1, 8'h08, 32'hffff);
    pulse(5'h01, 1'b0, 2'b0);
    rchk("flags", 8'h08, 16'h0001);
    // Filter clear empties the results
    xfer(1'b1, 8'h00, 32'h100);
    rchk("clearing", 8'h00, 16'h0100);
    `CHK("filter out", 1'b1, filter_clear)
    `CHK("run out", 1'b0, conversion_run)
    wait_low(8);
    `CHK("filter out", 1'b0, filter_clear)
    for (int k = 3; k < 7; k++)
      rchk("result", 8'(k * 4), 16'h0);
    xfer(1'b1, 8'h3c, 32'h1);
    rchk("ref ctl", 8'h34, 16'h01c5);
    `CHK("ref outs", 2'b11, ro)
    xfer(1'b1, 8'h3c, 32'h9);
    rchk("ref ctl", 8'h34, 16'h00c4);
    `CHK("ref outs", 2'b00, ro)
    xfer(1'b1, 8'h34, 32'h00c5);
    rchk("ref ctl", 8'h34, 16'h00c5);
    `CHK("ref outs", 2'b01, ro)
    // First peak sample replaces both extremes
    xfer(1'b1, 8'h38, 32'h20);
    dc_peak_sample <= 16'hfff0;
    ac_peak_sample <= 32'h0001_2345;
    pulse(5'h0, 1'b0, 2'b11);
    rchk("dc max", 8'h1c, 16'hfff0);
    rchk("dc min", 8'h20, 16'hfff0);
    for (int k = 9; k < 13; k++)
      rchk("ac peak", 8'(k * 4), k[0] ? 16'h2345 : 16'h0001);
    t0 = cyc;
    xfer(1'b1, 8'h00, 32'h200);
    rchk("clearing", 8'h00, 16'h0200);
    wait_low(9);
    `CHK("clear time", 1'b1, cyc - t0 <= 815)
    for (int k = 7; k < 13; k++)
      rchk("peak", 8'(k * 4), rv[k]);
    close_out();
  end
endmodule

// ### testbench/meter_ctrl_props.sv
/*
  Assertion checker for the meter converter control block.
  Assumes zero-wait APB; bound to the block's ports below.
*/
`timescale 1ns/10ps
module meter_ctrl_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [4:0] stage_done,
  input wire logic continuity_change,
  input wire logic conversion_run,
  input wire logic filter_clear,
  input wire logic analog_clock_gate,
  input wire logic reference_enable,
  input wire logic irq
);
  // ----------
  // Helpers
  // ----------
  logic wr; // Write landing at this edge
  logic ev; // Any flag cause this cycle
  assign wr = psel && penable && pready && pwrite;
  assign ev = |stage_done || continuity_change;
  // One domain, so one clock and reset serve all
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------
  // Assertions
  // ----------
  answer_ready_a : assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  run_bit_a : assert property (
    wr && paddr == 8'h00 |=> ##1 conversion_run == $past(pwdata[1], 2))
    else $error("run output lost");
  filter_start_a : assert property (
    wr && paddr == 8'h00 && pwdata[8] |=> ##1 filter_clear)
    else $error("filter clear not started");
  filter_end_a : assert property (
    $rose(filter_clear) |-> ##[1:40] !filter_clear)
    else $error("filter clear stuck");
  ref_write_a : assert property (
    wr && paddr == 8'h34 |=> ##1 reference_enable == $past(pwdata[0], 2)
      && analog_clock_gate == $past(pwdata[8], 2))
    else $error("reference outputs lost");
  mode_load_a : assert property (
    wr && paddr == 8'h3c |=> ##1 {2{$past(pwdata[3:0], 2) != 4'h9}}
      == {reference_enable, analog_clock_gate})
    else $error("mode write did not load");
  irq_cause_a : assert property (
    $rose(irq) |-> $past(ev, 2) || $past(wr, 2))
    else $error("interrupt without cause");
  irq_clear_a : assert property (
    $fell(irq) |-> $past(wr, 2))
    else $error("interrupt fell without write");
  // Main scenarios reached
  cover property (wr && paddr == 8'h00 && pwdata[9]);
  cover property ($rose(irq));
  cover property ($fell(filter_clear));
endmodule
bind meter_converter_ctrl meter_ctrl_props meter_ctrl_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .stage_done(stage_done), .continuity_change(continuity_change),
  .conversion_run(conversion_run), .filter_clear(filter_clear),
  .analog_clock_gate(analog_clock_gate),
  .reference_enable(reference_enable), .irq(irq)
);
